// ---- verilog/rtu_slave_register_reader.sv ----
// Slave frame engine: silence framing, checks, read requests and replies
`timescale 1ns/1ps
`default_nettype none

module rtu_slave_register_reader #(
  parameter int SILENCE_CYCLES = rtu_reader_pkg::SILENCE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Node identity
  input  wire logic [7:0]  node_addr_in,
  // Received characters
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_char_err_in,
  // Reply characters
  output var  logic        tx_valid_out,
  output var  logic [7:0]  tx_data_out,
  input  wire logic        tx_ready_in,
  // Register read port
  output var  logic        reg_rd_en_out,
  output var  logic        reg_rd_input_out,
  output var  logic [15:0] reg_rd_addr_out,
  input  wire logic [15:0] reg_rd_data_in,
  // Status
  output var  logic        link_idle_out,
  output var  logic        frame_drop_out
);

  // ************************************************************
  // State
  // ************************************************************
  rtu_reader_pkg::state_type state_r;
  rtu_reader_pkg::state_type state_nxt;
  logic [rtu_reader_pkg::TIMER_W-1:0] timer_r;
  logic [rtu_reader_pkg::TIMER_W-1:0] timer_nxt;
  logic [8:0]  len_r;
  logic [8:0]  len_nxt;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic        bad_r;
  logic        bad_nxt;
  logic        foreign_r;
  logic        foreign_nxt;
  logic [7:0]  func_r;
  logic [7:0]  func_nxt;
  logic [15:0] start_r;
  logic [15:0] start_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0]  exc_r;
  logic [7:0]  exc_nxt;
  logic [1:0]  hdr_idx_r;
  logic [1:0]  hdr_idx_nxt;
  logic [15:0] word_r;
  logic [15:0] word_nxt;
  logic        rd_en_r;
  logic        rd_en_nxt;
  logic        drop_r;
  logic        drop_nxt;
  logic        idle_r;
  logic        idle_nxt;
  logic        rd_input_r;
  logic        rd_input_nxt;

  logic        push_valid;
  logic [7:0]  push_data;
  logic        push_ready;
  logic        silent;
  logic [16:0] reg_end;
  logic [16:0] reg_limit;
  logic        is_read;

  localparam logic [rtu_reader_pkg::TIMER_W-1:0] SILENCE_LAST =
    rtu_reader_pkg::TIMER_W'(SILENCE_CYCLES - 1);
  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    state_nxt   = state_r;
    timer_nxt   = timer_r;
    len_nxt     = len_r;
    crc_nxt     = crc_r;
    bad_nxt     = bad_r;
    foreign_nxt = foreign_r;
    func_nxt    = func_r;
    start_nxt   = start_r;
    count_nxt   = count_r;
    exc_nxt     = exc_r;
    hdr_idx_nxt = hdr_idx_r;
    word_nxt    = word_r;
    rd_en_nxt   = 1'b0;
    drop_nxt    = 1'b0;
    push_valid  = 1'b0;
    push_data   = 8'h00;
    silent      = (timer_r == SILENCE_LAST);
    is_read     = (func_r == rtu_reader_pkg::FUNC_READ_HOLDING) ||
                  (func_r == rtu_reader_pkg::FUNC_READ_INPUT);
    reg_end     = {1'b0, start_r} + {1'b0, count_r};
    reg_limit   = (func_r == rtu_reader_pkg::FUNC_READ_INPUT) ?
                  rtu_reader_pkg::INPUT_REGS : rtu_reader_pkg::HOLDING_REGS;

    case (state_r)
      rtu_reader_pkg::ST_INIT:
      begin
        // Any character restarts the quiet wait
        timer_nxt = rx_valid_in ? '0 : timer_r + 1'b1;
        if (silent && !rx_valid_in)
          state_nxt = rtu_reader_pkg::ST_IDLE;
      end
      rtu_reader_pkg::ST_IDLE:
      begin
        if (rx_valid_in)
        begin
          state_nxt   = rtu_reader_pkg::ST_ACTIVE;
          timer_nxt   = '0;
          len_nxt     = 9'h001;
          crc_nxt     = rtu_reader_pkg::crc_byte(rtu_reader_pkg::CRC_INIT, rx_data_in);
          bad_nxt     = rx_char_err_in;
          foreign_nxt = (rx_data_in != node_addr_in);
        end
      end

      rtu_reader_pkg::ST_ACTIVE:
      begin
        timer_nxt = rx_valid_in ? '0 : timer_r + 1'b1;
        if (rx_valid_in)
        begin
          crc_nxt = rtu_reader_pkg::crc_byte(crc_r, rx_data_in);
          // Saturates at the limit so an overlong frame stays marked
          bad_nxt = bad_r || rx_char_err_in ||
                    (len_r == rtu_reader_pkg::MAX_FRAME_LEN);
          len_nxt = (len_r == rtu_reader_pkg::MAX_FRAME_LEN) ? len_r : len_r + 1'b1;
          case (len_r)
            rtu_reader_pkg::IDX_FUNC:     func_nxt = rx_data_in;
            rtu_reader_pkg::IDX_START_HI: start_nxt[15:8] = rx_data_in;
            rtu_reader_pkg::IDX_START_LO: start_nxt[7:0]  = rx_data_in;
            rtu_reader_pkg::IDX_COUNT_HI: count_nxt[15:8] = rx_data_in;
            rtu_reader_pkg::IDX_COUNT_LO: count_nxt[7:0]  = rx_data_in;
            default:                      func_nxt = func_r;
          endcase
        end
        else if (silent)
          state_nxt = rtu_reader_pkg::ST_CHECK;
      end
      rtu_reader_pkg::ST_CHECK:
      begin
        // Checksum is judged before the address, as ordered
        state_nxt   = rtu_reader_pkg::ST_HDR;
        hdr_idx_nxt = 2'd0;
        exc_nxt     = 8'h00;
        crc_nxt     = rtu_reader_pkg::CRC_INIT;
        if (bad_r || len_r < rtu_reader_pkg::MIN_FRAME_LEN ||
            crc_r != rtu_reader_pkg::CRC_GOOD || foreign_r)
        begin
          state_nxt = rtu_reader_pkg::ST_IDLE;
          drop_nxt  = 1'b1;
        end
        else if (func_r == rtu_reader_pkg::FUNC_INVALID || func_r[7])
        begin
          state_nxt = rtu_reader_pkg::ST_IDLE;
          drop_nxt  = 1'b1;
        end
        else if (!is_read)
          exc_nxt = rtu_reader_pkg::EXC_BAD_FUNC;
        else if (len_r != rtu_reader_pkg::READ_REQ_LEN)
        begin
          state_nxt = rtu_reader_pkg::ST_IDLE;
          drop_nxt  = 1'b1;
        end
        else if (count_r < rtu_reader_pkg::MIN_REG_COUNT ||
                 count_r > rtu_reader_pkg::MAX_REG_COUNT)
          exc_nxt = rtu_reader_pkg::EXC_BAD_COUNT;
        else if (reg_end > reg_limit)
          exc_nxt = rtu_reader_pkg::EXC_BAD_ADDR;
      end
      rtu_reader_pkg::ST_HDR:
      begin
        push_valid = 1'b1;
        case (hdr_idx_r)
          2'd0:    push_data = node_addr_in;
          2'd1:    push_data = (exc_r != 8'h00) ?
                               (func_r | rtu_reader_pkg::FUNC_EXC_FLAG) : func_r;
          default: push_data = (exc_r != 8'h00) ? exc_r : {count_r[6:0], 1'b0};
        endcase
        if (push_ready)
        begin
          crc_nxt     = rtu_reader_pkg::crc_byte(crc_r, push_data);
          hdr_idx_nxt = hdr_idx_r + 1'b1;
          if (hdr_idx_r == 2'd2)
            state_nxt = (exc_r != 8'h00) ? rtu_reader_pkg::ST_CRCL : rtu_reader_pkg::ST_FETCH;
        end
      end
      rtu_reader_pkg::ST_FETCH:
      begin
        rd_en_nxt = 1'b1;
        state_nxt = rtu_reader_pkg::ST_WAIT;
      end

      rtu_reader_pkg::ST_WAIT:
      begin
        state_nxt = rtu_reader_pkg::ST_LATCH;
      end

      rtu_reader_pkg::ST_LATCH:
      begin
        word_nxt  = reg_rd_data_in;
        state_nxt = rtu_reader_pkg::ST_DHI;
      end
      rtu_reader_pkg::ST_DHI,
      rtu_reader_pkg::ST_DLO:
      begin
        push_valid = 1'b1;
        push_data  = (state_r == rtu_reader_pkg::ST_DHI) ? word_r[15:8] : word_r[7:0];
        if (push_ready)
        begin
          crc_nxt   = rtu_reader_pkg::crc_byte(crc_r, push_data);
          state_nxt = rtu_reader_pkg::ST_DLO;
          if (state_r == rtu_reader_pkg::ST_DLO)
          begin
            start_nxt = start_r + 1'b1;
            count_nxt = count_r - 1'b1;
            state_nxt = (count_r == 16'h0001) ? rtu_reader_pkg::ST_CRCL : rtu_reader_pkg::ST_FETCH;
          end
        end
      end
      rtu_reader_pkg::ST_CRCL,
      rtu_reader_pkg::ST_CRCH:
      begin
        push_valid = 1'b1;
        push_data  = (state_r == rtu_reader_pkg::ST_CRCL) ? crc_r[7:0] : crc_r[15:8];
        if (push_ready)
          state_nxt = (state_r == rtu_reader_pkg::ST_CRCL) ? rtu_reader_pkg::ST_CRCH :
                      rtu_reader_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt = rtu_reader_pkg::ST_INIT;
        timer_nxt = '0;
      end
    endcase
    idle_nxt     = (state_nxt == rtu_reader_pkg::ST_IDLE);
    rd_input_nxt = (func_nxt == rtu_reader_pkg::FUNC_READ_INPUT);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r   <= rtu_reader_pkg::ST_INIT;
      timer_r   <= '0;
      len_r     <= 9'h000;
      crc_r     <= rtu_reader_pkg::CRC_INIT;
      bad_r     <= 1'b0;
      foreign_r <= 1'b0;
      func_r    <= 8'h00;
      start_r   <= 16'h0000;
      count_r   <= 16'h0000;
      exc_r     <= 8'h00;
      hdr_idx_r <= 2'd0;
      word_r    <= 16'h0000;
      rd_en_r   <= 1'b0;
      drop_r    <= 1'b0;
      idle_r    <= 1'b0;
      rd_input_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      timer_r   <= timer_nxt;
      len_r     <= len_nxt;
      crc_r     <= crc_nxt;
      bad_r     <= bad_nxt;
      foreign_r <= foreign_nxt;
      func_r    <= func_nxt;
      start_r   <= start_nxt;
      count_r   <= count_nxt;
      exc_r     <= exc_nxt;
      hdr_idx_r <= hdr_idx_nxt;
      word_r    <= word_nxt;
      rd_en_r   <= rd_en_nxt;
      drop_r    <= drop_nxt;
      idle_r    <= idle_nxt;
      rd_input_r <= rd_input_nxt;
    end
  end

  // ************************************************************
  // Reply buffer
  // ************************************************************
  // A stalled line holds the sequencer; no reply byte is lost
  tx_skid_buffer #(.WIDTH(8)) u_tx_buffer (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push_valid),
    .in_data_in    (push_data),
    .in_ready_out  (push_ready),
    .out_valid_out (tx_valid_out),
    .out_data_out  (tx_data_out),
    .out_ready_in  (tx_ready_in)
  );

  assign reg_rd_en_out    = rd_en_r;
  assign reg_rd_addr_out  = start_r;
  assign reg_rd_input_out = rd_input_r;
  assign link_idle_out    = idle_r;
  assign frame_drop_out   = drop_r;

endmodule

`default_nettype wire

// ---- verilog/rtu_reader_pkg.sv ----
// Constants, types and helpers shared by the serial-line register reader
package rtu_reader_pkg;

  // ************************************************************
  // Line timing
  // ************************************************************
  localparam int  CLK_HZ        = 250_000_000;
  localparam int  BAUD_RATE     = 9600;
  localparam int  CHAR_BITS     = 11;
  localparam real SILENCE_CHARS = 3.5;
  // Least time, so rounded up to whole cycles
  localparam int  SILENCE_CYCLES =
    int'($ceil(SILENCE_CHARS * real'(CHAR_BITS) * real'(CLK_HZ) / real'(BAUD_RATE)));
  localparam int  TIMER_W       = 24;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [8:0] MAX_FRAME_LEN = 9'h100;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] READ_REQ_LEN  = 9'h008;
  localparam logic [8:0] IDX_ADDR      = 9'h000;
  localparam logic [8:0] IDX_FUNC      = 9'h001;
  localparam logic [8:0] IDX_START_HI  = 9'h002;
  localparam logic [8:0] IDX_START_LO  = 9'h003;
  localparam logic [8:0] IDX_COUNT_HI  = 9'h004;
  localparam logic [8:0] IDX_COUNT_LO  = 9'h005;

  // ************************************************************
  // Function and exception codes
  // ************************************************************
  localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FUNC_READ_INPUT   = 8'h04;
  localparam logic [7:0] FUNC_INVALID      = 8'h00;
  localparam logic [7:0] FUNC_EXC_FLAG     = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC      = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR      = 8'h02;
  localparam logic [7:0] EXC_BAD_COUNT     = 8'h03;

  // ************************************************************
  // Register space and counts
  // ************************************************************
  localparam logic [15:0] MIN_REG_COUNT = 16'h0001;
  localparam logic [15:0] MAX_REG_COUNT = 16'h007D;
  localparam logic [16:0] HOLDING_REGS  = 17'h0_0010;
  localparam logic [16:0] INPUT_REGS    = 17'h0_0010;

  // ************************************************************
  // Checksum
  // ************************************************************
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_ACTIVE, ST_CHECK, ST_HDR, ST_FETCH,
    ST_WAIT, ST_LATCH, ST_DHI, ST_DLO, ST_CRCL, ST_CRCH
  } state_type;

  // One byte through the reflected checksum
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ---- verilog/tx_skid_buffer.sv ----
// Two-entry buffer with registered outputs on the reply byte path
`timescale 1ns/1ps
`default_nettype none

module tx_skid_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             in_ready_out,
  // Draining side
  output var  logic             out_valid_out,
  output var  logic [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  logic             out_valid_r;
  logic             out_valid_nxt;
  logic [WIDTH-1:0] out_data_r;
  logic [WIDTH-1:0] out_data_nxt;
  logic             skid_valid_r;
  logic             skid_valid_nxt;
  logic [WIDTH-1:0] skid_data_r;
  logic [WIDTH-1:0] skid_data_nxt;
  logic             push;

  // Ready only while the skid slot is free, so a stalled drain fills both
  always_comb
  begin
    push           = in_valid_in && !skid_valid_r;
    out_valid_nxt  = out_valid_r;
    out_data_nxt   = out_data_r;
    skid_valid_nxt = skid_valid_r;
    skid_data_nxt  = skid_data_r;
    if (!out_valid_r || out_ready_in)
    begin
      out_valid_nxt  = skid_valid_r || push;
      out_data_nxt   = skid_valid_r ? skid_data_r : in_data_in;
      skid_valid_nxt = 1'b0;
    end
    else if (push)
    begin
      skid_valid_nxt = 1'b1;
      skid_data_nxt  = in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_valid_r  <= 1'b0;
      out_data_r   <= '0;
      skid_valid_r <= 1'b0;
      skid_data_r  <= '0;
    end
    else
    begin
      out_valid_r  <= out_valid_nxt;
      out_data_r   <= out_data_nxt;
      skid_valid_r <= skid_valid_nxt;
      skid_data_r  <= skid_data_nxt;
    end
  end

  assign in_ready_out  = !skid_valid_r;
  assign out_valid_out = out_valid_r;
  assign out_data_out  = out_data_r;

endmodule

`default_nettype wire

// ---- test/rtu_reader_props.sv ----
// Port checker for the serial register reader
`timescale 1ns/1ps
`default_nettype none

module rtu_reader_props #(
  parameter int SILENCE_CYCLES = 40
) (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [7:0]  node_addr_in,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        rx_char_err_in,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_ready_in,
  input wire logic        reg_rd_en_out,
  input wire logic        reg_rd_input_out,
  input wire logic [15:0] reg_rd_addr_out,
  input wire logic [15:0] reg_rd_data_in,
  input wire logic        link_idle_out,
  input wire logic        frame_drop_out
);
  // **********
  // Helpers
  // **********
  int   quiet_r;
  logic in_reply_r;

  // Saturates so long silences cannot wrap
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      quiet_r    <= 0;
      in_reply_r <= 1'b0;
    end
    else
    begin
      quiet_r <= rx_valid_in ? 0 : ((quiet_r < SILENCE_CYCLES) ? quiet_r + 1 : quiet_r);
      if (tx_valid_out && tx_ready_in)
        in_reply_r <= 1'b1;
      else if (link_idle_out && rx_valid_in)
        in_reply_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_rd;
    reg_rd_en_out;
  endsequence
  sequence s_stall;
    tx_valid_out && !tx_ready_in;
  endsequence

  // **********
  // Properties
  // **********
  AST_IDLE_WAIT: assert property ($rose(link_idle_out) |-> quiet_r >= SILENCE_CYCLES - 1)
    else $error("idle entered before silence");
  AST_IDLE_LEAVE: assert property (link_idle_out && rx_valid_in |=> !link_idle_out)
    else $error("character in idle did not start frame");
  AST_DROP_PULSE: assert property (frame_drop_out |=> !frame_drop_out)
    else $error("drop pulse too long");
  AST_DROP_SILENT: assert property (frame_drop_out |=> !tx_valid_out [*4])
    else $error("reply after dropped frame");
  AST_TX_HOLD: assert property (s_stall |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte lost under stall");
  AST_RD_SPACING: assert property (s_rd |=> !reg_rd_en_out [*4])
    else $error("register reads too close");
  AST_RD_STABLE: assert property (s_rd |=> $stable(reg_rd_addr_out) && $stable(reg_rd_input_out))
    else $error("read address moved before sample");
  AST_REPLY_ADDR: assert property (tx_valid_out && !in_reply_r |-> tx_data_out == node_addr_in)
    else $error("reply does not open with node address");
  AST_IDLE_NO_READ: assert property (link_idle_out |-> !reg_rd_en_out)
    else $error("register read while idle");
endmodule

bind rtu_slave_register_reader rtu_reader_props #(
  .SILENCE_CYCLES(SILENCE_CYCLES)
) chk (
  .clk_in          (clk_in),
  .reset_n_in      (reset_n_in),
  .node_addr_in    (node_addr_in),
  .rx_valid_in     (rx_valid_in),
  .rx_data_in      (rx_data_in),
  .rx_char_err_in  (rx_char_err_in),
  .tx_valid_out    (tx_valid_out),
  .tx_data_out     (tx_data_out),
  .tx_ready_in     (tx_ready_in),
  .reg_rd_en_out   (reg_rd_en_out),
  .reg_rd_input_out(reg_rd_input_out),
  .reg_rd_addr_out (reg_rd_addr_out),
  .reg_rd_data_in  (reg_rd_data_in),
  .link_idle_out   (link_idle_out),
  .frame_drop_out  (frame_drop_out)
);

`default_nettype wire

// ---- test/rtu_master_model.sv ----
// Far-side model: reply sink with pacing and register bank
`timescale 1ns/1ps
`default_nettype none

module rtu_master_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Scenario control
  input  wire logic        slow_in,
  // Reply sink
  output var  logic        tx_ready_out,
  // Register bank
  input  wire logic        rd_en_in,
  input  wire logic        rd_input_in,
  input  wire logic [15:0] rd_addr_in,
  output var  logic [15:0] rd_data_out
);
  logic [1:0] pace_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pace_r      <= 2'h0;
      rd_data_out <= 16'h0000;
    end
    else
    begin
      pace_r <= pace_r + 2'h1;
      // Valid only in the sample cycle, scrambled otherwise
      rd_data_out <= rd_en_in ? {rd_input_in ? 8'h9C : 8'h51, rd_addr_in[7:0]} : ~rd_data_out;
    end
  end

  // Slow mode takes one byte in four
  assign tx_ready_out = !slow_in || (pace_r == 2'h0);
endmodule

`default_nettype wire

// ---- test/rtu_slave_register_reader_tb.sv ----
// Self-checking bench for the serial register reader
`timescale 1ns/1ps
`default_nettype none

module rtu_slave_register_reader_tb;
  // **********
  // Signals
  // **********
  localparam int         S    = 40;
  localparam logic [7:0] NODE = 8'h2A;
  logic        clk_in         = 1'b0;
  logic        reset_n_in     = 1'b0;
  logic        rx_valid_in    = 1'b0;
  logic [7:0]  rx_data_in     = 8'h00;
  logic        rx_char_err_in = 1'b0;
  logic        stall          = 1'b0;
  logic        drop_seen      = 1'b0;
  logic        tx_valid_out;
  logic        tx_ready_in;
  logic        reg_rd_en_out;
  logic        reg_rd_input_out;
  logic        link_idle_out;
  logic        frame_drop_out;
  logic [7:0]  tx_data_out;
  logic [15:0] reg_rd_addr_out;
  logic [15:0] reg_rd_data_in;
  logic [7:0]  got_q[$];
  int          num_errors     = 0;
  int          cmp_count      = 0;

  always #2 clk_in = ~clk_in;

  rtu_slave_register_reader #(
    .SILENCE_CYCLES(S)
  ) uut (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .node_addr_in    (NODE),
    .rx_valid_in     (rx_valid_in),
    .rx_data_in      (rx_data_in),
    .rx_char_err_in  (rx_char_err_in),
    .tx_valid_out    (tx_valid_out),
    .tx_data_out     (tx_data_out),
    .tx_ready_in     (tx_ready_in),
    .reg_rd_en_out   (reg_rd_en_out),
    .reg_rd_input_out(reg_rd_input_out),
    .reg_rd_addr_out (reg_rd_addr_out),
    .reg_rd_data_in  (reg_rd_data_in),
    .link_idle_out   (link_idle_out),
    .frame_drop_out  (frame_drop_out)
  );

  rtu_master_model master (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .slow_in     (stall),
    .tx_ready_out(tx_ready_in),
    .rd_en_in    (reg_rd_en_out),
    .rd_input_in (reg_rd_input_out),
    .rd_addr_in  (reg_rd_addr_out),
    .rd_data_out (reg_rd_data_in)
  );

  always @(posedge clk_in)
  begin
    if (tx_valid_out && tx_ready_in)
      got_q.push_back(tx_data_out);
    if (frame_drop_out)
      drop_seen <= 1'b1;
  end

  // **********
  // Helpers
  // **********
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // Checksum goes out low byte first
  task automatic seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask

  task automatic send(input logic [7:0] q[$], input logic err);
    got_q.delete();
    drop_seen = 1'b0;
    foreach (q[i])
    begin
      @(negedge clk_in);
      rx_valid_in = 1'b1;
      rx_data_in = q[i];
      rx_char_err_in = err && (i == q.size() - 1);
      @(negedge clk_in);
      rx_valid_in = 1'b0;
      rx_char_err_in = 1'b0;
      repeat (3) @(negedge clk_in);
    end
  endtask

  task automatic transact(input logic [7:0] req[$], input logic [7:0] exp[$], input logic err);
    int n;
    send(req, err);
    n = 0;
    while (!(link_idle_out === 1'b1 && tx_valid_out === 1'b0))
    begin
      @(negedge clk_in);
      n++;
      if (n > 5000)
      begin
        num_errors++;
        $display("CHECK FAILED at %0t: reply timeout", $time);
        close_out();
      end
    end
    repeat (4) @(negedge clk_in);
    check(16'(got_q.size()), 16'(exp.size()));
    foreach (exp[i])
      if (i < got_q.size())
        check({8'h00, got_q[i]}, {8'h00, exp[i]});
  endtask

  // **********
  // Scenarios
  // **********
  task automatic t_init();
    repeat (20) @(negedge clk_in);
    send('{8'h55}, 1'b0);
    repeat (S - 10) @(negedge clk_in);
    check({15'h0000, link_idle_out}, 16'h0000);
    repeat (10) @(negedge clk_in);
    check({15'h0000, link_idle_out}, 16'h0001);
    $display("init wait done");
  endtask

  task automatic t_reads();
    logic [7:0] req[$];
    logic [7:0] exp[$];
    req = '{NODE, 8'h03, 8'h00, 8'h0D, 8'h00, 8'h03};
    exp = '{NODE, 8'h03, 8'h06, 8'h51, 8'h0D, 8'h51, 8'h0E, 8'h51, 8'h0F};
    seal(req);
    seal(exp);
    stall = 1'b1;
    transact(req, exp, 1'b0);
    stall = 1'b0;
    req = '{NODE, 8'h04, 8'h00, 8'h0F, 8'h00, 8'h01};
    exp = '{NODE, 8'h04, 8'h02, 8'h9C, 8'h0F};
    seal(req);
    seal(exp);
    transact(req, exp, 1'b0);
    $display("reads done");
  endtask

  task automatic t_exc();
    logic [47:0] tbl [7];
    logic [7:0]  req[$];
    logic [7:0]  exp[$];
    tbl = '{48'h0100_0001_8101, 48'h0500_0001_8501, 48'h0300_0000_8303,
            48'h0400_007E_8403, 48'h030F_0002_8302, 48'h0410_0001_8402,
            48'h0300_007D_8302};
    foreach (tbl[i])
    begin
      req = '{NODE, tbl[i][47:40], 8'h00, tbl[i][39:32], tbl[i][31:24], tbl[i][23:16]};
      exp = '{NODE, tbl[i][15:8], tbl[i][7:0]};
      seal(req);
      seal(exp);
      transact(req, exp, 1'b0);
    end
    $display("exceptions done");
  endtask

  task automatic t_drop();
    logic [7:0] req[$];
    logic [7:0] none[$];
    for (int k = 0; k < 7; k++)
    begin
      req = '{NODE, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
      case (k)
        0: req[0] = NODE + 8'h01;
        2: req[1] = 8'h00;
        3: req[1] = 8'h83;
        6: req.push_back(8'h00);
        default: ;
      endcase
      seal(req);
      if (k == 1)
        req[7] = ~req[7];
      if (k == 5)
        req = '{NODE, 8'h03, 8'h00};
      transact(req, none, k == 4);
      check({15'h0000, drop_seen}, 16'h0001);
    end
    $display("drops done");
  endtask

  initial
  begin
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    t_init();
    t_reads();
    t_exc();
    t_drop();
    close_out();
  end
endmodule

`default_nettype wire
